// ===== hdl/flash_cfg_pkg.sv
// Constants and carrier types for the command-behaviour configuration bank.
package flash_cfg_pkg;

    // Instruction codes seen on the decoded command stream.
    localparam logic [7:0] OP_READ_ANY_REG  = 8'h65;
    localparam logic [7:0] OP_WRITE_ANY_REG = 8'h71;
    localparam logic [7:0] OP_BURST_LEN_SET = 8'hC0;
    localparam logic [7:0] OP_RESUME_OR_CLR = 8'h30;
    localparam logic [7:0] OP_LEGACY_RESET  = 8'hF0;
    localparam logic [7:0] OP_RESET_ENABLE  = 8'h66;
    localparam logic [7:0] OP_RESET_DO      = 8'h99;

    // Register addresses inside the any-register space.
    localparam logic [7:0] ADDR_EPB_NV  = 8'h10;
    localparam logic [7:0] ADDR_EPB_V   = 8'h11;
    localparam logic [7:0] ADDR_WRAP_NV = 8'h12;
    localparam logic [7:0] ADDR_WRAP_V  = 8'h13;

    // Implemented bit masks; other positions are reserved and read zero, bar the read-only layout bit that EPB_V_WR_MASK omits.
    localparam logic [7:0] EPB_NV_MASK   = 8'h3D;
    localparam logic [7:0] EPB_V_WR_MASK = 8'h35;
    localparam logic [7:0] WRAP_MASK     = 8'hF3;

    // Field positions of the erase/program behaviour registers.
    localparam int BIT_BLANK_CHECK   = 5;
    localparam int BIT_PAGE_WRAP     = 4;
    localparam int BIT_SECTOR_LAYOUT = 3;
    localparam int BIT_RESUME_SELECT = 2;
    localparam int BIT_LEGACY_RESET  = 0;

    // Field positions of the burst wrap registers.
    localparam int BIT_WRAP_DISABLE = 4;
    localparam int DRIVE_MSB        = 7;
    localparam int DRIVE_LSB        = 5;
    localparam logic [2:0] DRIVE_DEFAULT_CODE = 3'h0;
    localparam logic [2:0] DRIVE_DEFAULT_EQ   = 3'h3;

    // Geometry constants.
    localparam logic [6:0] WRAP_BASE_BYTES = 7'h08;
    localparam int PARAM_REGION_BITS = 15;

    // Erase kinds.
    localparam logic [1:0] ERASE_PARAM  = 2'h0;
    localparam logic [1:0] ERASE_SECTOR = 2'h1;
    localparam logic [1:0] ERASE_BULK   = 2'h2;

    // One decoded instruction from the serial front end.
    typedef struct packed {
        logic       valid;
        logic [7:0] code;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cmd_type;

    // Erase sequencing states.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SCAN
    } erase_state_type;

endpackage : flash_cfg_pkg

// ===== hdl/flash_cmd_behaviour_config.sv
// Command-behaviour configuration bank with erase, wrap and reset decisions.
// How it works
// R1: Blank check on: a failed last erase forces an unconditional erase.
// R2: Blank check with good last erase scans; first zero starts erase, else skip.
// R3: Blank check covers parameter, sector and bulk erase; off means erase at once.
// R4: Page wrap bit 0 wraps loads at 256 bytes; 1 uses all 512.
// R5: Volatile layout bit is read-only; 1 uniform, 0 hybrid with 4-KB sectors.
// R6: Hybrid puts parameter sectors on top or bottom 32 KB; uniform has none.
// R7: Host never writes volatile layout bit differently from its non-volatile copy.
// R8: Instruction 30h means resume when select is 1, clear status when 0.
// R9: F0h performs software reset only when legacy reset is enabled.
// R10: Sequence 66h then 99h always performs software reset.
// R11: Burst wrap applies only to main-array reads, never registers or OTP.
// R12: Any reset copies non-volatile burst wrap register into the volatile one.
// R13: Set-burst-length C0h also writes the volatile burst wrap register.
// R14: Wrap enable 0 enables wrapping, only for quad and DDR quad I/O reads.
// R15: Wrap length 00/01/10/11 gives 8/16/32/64 bytes.
// R16: Three-bit drive select; code 000 drives like code 011.
// R17: Registers are read by 65h and written by 71h.
// R18: Each non-volatile bit may flip to its opposite state only once.
// R19: Reserved bits ignore writes and read as zero.
`timescale 1ns/10ps
module flash_cmd_behaviour_config
    import flash_cfg_pkg::*;
#(
    parameter logic [7:0] EPB_NV_INIT  = 8'h00,
    parameter logic [7:0] WRAP_NV_INIT = 8'h00,
    parameter int         ADDR_W       = 26
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire cmd_type           cmd,
    input  wire logic              hw_reset_req,
    input  wire logic              erase_req,
    input  wire logic [1:0]        erase_kind,
    input  wire logic              prev_erase_ok,
    input  wire logic              scan_zero_found,
    input  wire logic              scan_done,
    input  wire logic              load_valid,
    input  wire logic [8:0]        load_addr,
    input  wire logic              param_at_top,
    input  wire logic [ADDR_W-1:0] array_addr,
    input  wire logic              read_is_quad_io,
    input  wire logic              read_is_main_array,
    output logic [7:0]             rd_data,
    output logic                   rd_valid,
    output logic                   erase_start,
    output logic                   scan_start,
    output logic                   erase_skip,
    output logic                   erase_reject,
    output logic [8:0]             page_buf_index,
    output logic                   in_param_sector,
    output logic                   resume_pulse,
    output logic                   clear_status_pulse,
    output logic                   soft_reset_pulse,
    output logic                   wrap_active,
    output logic [6:0]             wrap_bytes,
    output logic [2:0]             output_drive_select
);

    logic [1:0]      rst_sync;
    logic            rst_n;
    logic [7:0]      erase_program_behavior_cfg_nonvolatile;
    logic [7:0]      erase_program_behavior_cfg_volatile;
    logic [7:0]      burst_wrap_cfg_nonvolatile;
    logic [7:0]      burst_wrap_cfg_volatile;

    logic [7:0]      epb_used;
    logic [7:0]      wrap_used;
    logic            reset_armed;
    logic            reload;
    logic            wr_any;
    erase_state_type state;
    logic [2:0]      drive_code;
    logic [ADDR_W-PARAM_REGION_BITS-1:0] region;

    // Reset release is synchronised so every flop reset by rst_n leaves reset on the same edge.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Volatile copies reload on hardware or software reset; power-on is rst_b.
    assign reload = soft_reset_pulse | hw_reset_req; // [R12]
    assign wr_any = cmd.valid && (cmd.code == OP_WRITE_ANY_REG); // [R17]

    // Non-volatile bits: a bit that has flipped once is frozen afterwards.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            erase_program_behavior_cfg_nonvolatile <= EPB_NV_INIT & EPB_NV_MASK;
            burst_wrap_cfg_nonvolatile             <= WRAP_NV_INIT & WRAP_MASK;
            epb_used                               <= 8'h00;
            wrap_used                              <= 8'h00;
        end else if (wr_any && cmd.addr == ADDR_EPB_NV) begin
            erase_program_behavior_cfg_nonvolatile <=
                (erase_program_behavior_cfg_nonvolatile & epb_used)
                | (cmd.wdata & ~epb_used & EPB_NV_MASK); // [R18] [R19]
            epb_used <= epb_used
                | ((cmd.wdata ^ erase_program_behavior_cfg_nonvolatile) & EPB_NV_MASK);
        end else if (wr_any && cmd.addr == ADDR_WRAP_NV) begin
            burst_wrap_cfg_nonvolatile <= (burst_wrap_cfg_nonvolatile & wrap_used)
                | (cmd.wdata & ~wrap_used & WRAP_MASK); // [R18] [R19]
            wrap_used <= wrap_used
                | ((cmd.wdata ^ burst_wrap_cfg_nonvolatile) & WRAP_MASK);
        end
    end

    // Volatile behaviour register; the layout bit always mirrors its stored copy.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            erase_program_behavior_cfg_volatile <= EPB_NV_INIT & EPB_NV_MASK;
        end else if (reload) begin
            erase_program_behavior_cfg_volatile <= erase_program_behavior_cfg_nonvolatile;
        end else if (wr_any && cmd.addr == ADDR_EPB_V) begin
            erase_program_behavior_cfg_volatile <= (cmd.wdata & EPB_V_WR_MASK) // [R19]
                | (erase_program_behavior_cfg_nonvolatile & ~EPB_V_WR_MASK & EPB_NV_MASK);
        end else begin
            // Ignoring host writes here keeps the layout honest even if the host slips.
            erase_program_behavior_cfg_volatile[BIT_SECTOR_LAYOUT] <=
                erase_program_behavior_cfg_nonvolatile[BIT_SECTOR_LAYOUT]; // [R5] [R7]
        end
    end

    // Volatile burst wrap register, written by 71h or by the burst length command.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            burst_wrap_cfg_volatile <= WRAP_NV_INIT & WRAP_MASK;
        end else if (reload) begin
            burst_wrap_cfg_volatile <= burst_wrap_cfg_nonvolatile; // [R12]
        end else if (cmd.valid && (cmd.code == OP_BURST_LEN_SET
                     || (wr_any && cmd.addr == ADDR_WRAP_V))) begin
            burst_wrap_cfg_volatile <= cmd.wdata & WRAP_MASK; // [R13] [R19]
        end
    end

    // Register read answers one cycle after 65h; unmapped addresses read zero.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data  <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= cmd.valid && (cmd.code == OP_READ_ANY_REG); // [R17]
            unique case (cmd.addr)
                ADDR_EPB_NV:  rd_data <= erase_program_behavior_cfg_nonvolatile;
                ADDR_EPB_V:   rd_data <= erase_program_behavior_cfg_volatile;
                ADDR_WRAP_NV: rd_data <= burst_wrap_cfg_nonvolatile;
                ADDR_WRAP_V:  rd_data <= burst_wrap_cfg_volatile;
                default:      rd_data <= 8'h00;
            endcase
        end
    end

    // Instruction decode for 30h and the two software reset forms.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resume_pulse       <= 1'b0;
            clear_status_pulse <= 1'b0;
            soft_reset_pulse   <= 1'b0;
            reset_armed        <= 1'b0;
        end else begin
            resume_pulse       <= cmd.valid && cmd.code == OP_RESUME_OR_CLR
                && erase_program_behavior_cfg_volatile[BIT_RESUME_SELECT]; // [R8]
            clear_status_pulse <= cmd.valid && cmd.code == OP_RESUME_OR_CLR
                && !erase_program_behavior_cfg_volatile[BIT_RESUME_SELECT]; // [R8]
            soft_reset_pulse   <= cmd.valid
                && ((cmd.code == OP_LEGACY_RESET
                     && erase_program_behavior_cfg_volatile[BIT_LEGACY_RESET]) // [R9]
                    || (cmd.code == OP_RESET_DO && reset_armed)); // [R10]
            // Any other instruction between 66h and 99h disarms the sequence.
            if (cmd.valid) begin
                reset_armed <= (cmd.code == OP_RESET_ENABLE); // [R10]
            end
        end
    end

    // Erase sequencing with optional blank check.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state        <= ST_IDLE;
            erase_start  <= 1'b0;
            scan_start   <= 1'b0;
            erase_skip   <= 1'b0;
            erase_reject <= 1'b0;
        end else begin
            erase_start  <= 1'b0;
            scan_start   <= 1'b0;
            erase_skip   <= 1'b0;
            erase_reject <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (erase_req) begin
                        if ((erase_kind == ERASE_PARAM
                             && erase_program_behavior_cfg_volatile[BIT_SECTOR_LAYOUT])
                            || erase_kind > ERASE_BULK) begin
                            erase_reject <= 1'b1; // [R6]
                        end else if (!erase_program_behavior_cfg_volatile[BIT_BLANK_CHECK]
                                     || !prev_erase_ok) begin
                            erase_start <= 1'b1; // [R1] [R3]
                        end else begin
                            scan_start <= 1'b1; // [R2] [R3]
                            state      <= ST_SCAN;
                        end
                    end
                end
                ST_SCAN: begin
                    // A zero found on the final word still forces the erase.
                    if (scan_zero_found) begin
                        erase_start <= 1'b1; // [R2]
                        state       <= ST_IDLE;
                    end else if (scan_done) begin
                        erase_skip <= 1'b1; // [R2]
                        state      <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Field slices for the output stage.
    assign drive_code = burst_wrap_cfg_volatile[DRIVE_MSB:DRIVE_LSB];
    assign region     = array_addr[ADDR_W-1:PARAM_REGION_BITS];

    // Page buffer index, parameter overlay, wrap and drive outputs.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            page_buf_index      <= 9'h000;
            in_param_sector     <= 1'b0;
            wrap_active         <= 1'b0;
            wrap_bytes          <= WRAP_BASE_BYTES;
            output_drive_select <= DRIVE_DEFAULT_EQ;
        end else begin
            if (load_valid) begin
                page_buf_index <= {load_addr[8]
                    & erase_program_behavior_cfg_volatile[BIT_PAGE_WRAP], load_addr[7:0]}; // [R4]
            end
            in_param_sector <= !erase_program_behavior_cfg_volatile[BIT_SECTOR_LAYOUT]
                && (param_at_top ? (&region) : (region == '0)); // [R5] [R6]
            wrap_active <= !burst_wrap_cfg_volatile[BIT_WRAP_DISABLE]
                && read_is_quad_io && read_is_main_array; // [R11] [R14]
            wrap_bytes  <= WRAP_BASE_BYTES << burst_wrap_cfg_volatile[1:0]; // [R15]
            output_drive_select <= (drive_code == DRIVE_DEFAULT_CODE)
                ? DRIVE_DEFAULT_EQ : drive_code; // [R16]
        end
    end

    // Checks beside the logic they guard.
    property p_reserved_zero;
        @(posedge clk) disable iff (!rst_n)
        (erase_program_behavior_cfg_volatile & ~EPB_NV_MASK) == 8'h00
            && (burst_wrap_cfg_volatile & ~WRAP_MASK) == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // [R19]
        else $error("Reserved bit set in a volatile register.");

    property p_layout_tracks;
        @(posedge clk) disable iff (!rst_n)
        $changed(erase_program_behavior_cfg_nonvolatile[BIT_SECTOR_LAYOUT])
        |=> erase_program_behavior_cfg_volatile[BIT_SECTOR_LAYOUT]
            == $past(erase_program_behavior_cfg_nonvolatile[BIT_SECTOR_LAYOUT]);
    endproperty
    a_layout_tracks: assert property (p_layout_tracks) // [R5]
        else $error("Volatile layout bit did not follow its stored copy.");

    property p_no_check_erase;
        @(posedge clk) disable iff (!rst_n)
        state == ST_IDLE && erase_req && erase_kind != ERASE_PARAM && erase_kind <= ERASE_BULK
            && (!erase_program_behavior_cfg_volatile[BIT_BLANK_CHECK] || !prev_erase_ok)
        |=> erase_start && !scan_start;
    endproperty
    a_no_check_erase: assert property (p_no_check_erase) // [R1]
        else $error("Erase did not start unconditionally.");

    property p_scan_result;
        @(posedge clk) disable iff (!rst_n)
        state == ST_SCAN && !scan_zero_found && scan_done |=> erase_skip && !erase_start;
    endproperty
    a_scan_result: assert property (p_scan_result) // [R2]
        else $error("Blank sector was not skipped.");

    property p_page_wrap;
        @(posedge clk) disable iff (!rst_n)
        load_valid && !erase_program_behavior_cfg_volatile[BIT_PAGE_WRAP]
        |=> !page_buf_index[8];
    endproperty
    a_page_wrap: assert property (p_page_wrap) // [R4]
        else $error("Page buffer index passed 255 with wrap at 256.");

    property p_resume_select;
        @(posedge clk) disable iff (!rst_n)
        cmd.valid && cmd.code == OP_RESUME_OR_CLR
        |=> resume_pulse == $past(erase_program_behavior_cfg_volatile[BIT_RESUME_SELECT])
            && clear_status_pulse != resume_pulse;
    endproperty
    a_resume_select: assert property (p_resume_select) // [R8]
        else $error("Instruction 30h decoded the wrong way.");

    property p_legacy_ignored;
        @(posedge clk) disable iff (!rst_n)
        cmd.valid && cmd.code == OP_LEGACY_RESET
            && !erase_program_behavior_cfg_volatile[BIT_LEGACY_RESET]
        |=> !soft_reset_pulse;
    endproperty
    a_legacy_ignored: assert property (p_legacy_ignored) // [R9]
        else $error("Disabled legacy reset was acted on.");

    property p_reset_pair;
        @(posedge clk) disable iff (!rst_n)
        cmd.valid && cmd.code == OP_RESET_ENABLE ##1 cmd.valid && cmd.code == OP_RESET_DO
        |=> soft_reset_pulse ##1 burst_wrap_cfg_volatile == $past(burst_wrap_cfg_nonvolatile);
    endproperty
    a_reset_pair: assert property (p_reset_pair) // [R10] [R12]
        else $error("Reset sequence did not reload the wrap register.");

    property p_drive_default;
        @(posedge clk) disable iff (!rst_n)
        drive_code == DRIVE_DEFAULT_CODE |=> output_drive_select == DRIVE_DEFAULT_EQ;
    endproperty
    a_drive_default: assert property (p_drive_default) // [R16]
        else $error("Default drive code did not map to the middle setting.");

    property p_hw_reload;
        @(posedge clk) disable iff (!rst_n)
        hw_reset_req |=> burst_wrap_cfg_volatile == $past(burst_wrap_cfg_nonvolatile);
    endproperty
    a_hw_reload: assert property (p_hw_reload) // [R12]
        else $error("Hardware reset did not reload the wrap register.");

    // Coverage of the main scenarios.
    c_scan_skip:  cover property (@(posedge clk) disable iff (!rst_n) erase_skip);
    c_erase_reject: cover property (@(posedge clk) disable iff (!rst_n)
        erase_reject);
    c_scan_erase: cover property (@(posedge clk) disable iff (!rst_n)
        state == ST_SCAN && scan_zero_found);
    c_soft_reset: cover property (@(posedge clk) disable iff (!rst_n) soft_reset_pulse);
    c_wrap_read:  cover property (@(posedge clk) disable iff (!rst_n) wrap_active);

endmodule : flash_cmd_behaviour_config

// ===== dv/cmd_host_model.sv
// Behavioural host that feeds decoded register commands to the bank.
`timescale 1ns/10ps
module cmd_host_model
    import flash_cfg_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rd_valid,
    input  wire logic [7:0] rd_data,
    input  wire logic       layout_nv,
    output cmd_type         cmd
);
    cmd_type    pend[$];
    logic [7:0] rsp[$];

    // Queue one command.
    task automatic push(input logic [7:0] code, addr, wdata);
        logic [7:0] w;
        w = wdata;
        // A volatile layout write always carries the current non-volatile value.
        if (code == OP_WRITE_ANY_REG && addr == ADDR_EPB_V) w[BIT_SECTOR_LAYOUT] = layout_nv;
        pend.push_back('{1'b1, code, addr, w});
    endtask : push

    // One command per falling edge; idle fields toggle.
    initial cmd = '0;
    always @(negedge clk) begin
        if (rd_valid) rsp.push_back(rd_data);
        if (pend.size() != 0) cmd <= pend.pop_front();
        else cmd <= '{1'b0, ~cmd.code, ~cmd.addr, ~cmd.wdata};
    end
endmodule : cmd_host_model

// ===== dv/flash_cmd_behaviour_config_tb.sv
// Self-checking bench for the command-behaviour configuration bank.
`timescale 1ns/10ps
module flash_cmd_behaviour_config_tb
    import flash_cfg_pkg::*;
;
    localparam int         AW        = 26;
    localparam logic [7:0] EPB_INIT  = 8'h24;
    localparam logic [7:0] WRAP_INIT = 8'h61;

    logic          clk;
    logic          rst_b = 1'b0;
    logic          hw_reset_req = 1'b0;
    logic          erase_req = 1'b0;
    logic [1:0]    erase_kind = 2'h0;
    logic          prev_erase_ok = 1'b0;
    logic          scan_zero_found = 1'b0;
    logic          scan_done = 1'b0;
    logic          load_valid = 1'b0;
    logic [8:0]    load_addr = 9'h000;
    logic          param_at_top = 1'b0;
    logic [AW-1:0] array_addr = '0;
    logic          read_is_quad_io = 1'b0;
    logic          read_is_main_array = 1'b0;
    cmd_type       cmd;
    logic [7:0]    rd_data;
    logic [8:0]    page_buf_index;
    logic [6:0]    wrap_bytes;
    logic [2:0]    output_drive_select;
    logic          rd_valid, erase_start, scan_start, erase_skip, erase_reject;
    logic          in_param_sector, resume_pulse, clear_status_pulse, soft_reset_pulse;
    logic          wrap_active;
    int            err_count = 0;
    int            checked = 0;
    int            cycles = 0;
    int            n_res = 0, n_clr = 0, n_soft = 0, e_res = 0, e_clr = 0, e_soft = 0;
    int            m_env = EPB_INIT & EPB_NV_MASK;
    int            m_ev = EPB_INIT & EPB_V_WR_MASK;
    int            m_wnv = WRAP_INIT & WRAP_MASK;
    int            m_wv = WRAP_INIT & WRAP_MASK;
    int            m_eu = 0, m_wu = 0;
    integer        seed = 32'hd7e0fc3d;

    flash_cmd_behaviour_config #(.EPB_NV_INIT(EPB_INIT), .WRAP_NV_INIT(WRAP_INIT), .ADDR_W(AW))
        flash_cmd_behaviour_config_inst (.*);

    cmd_host_model cmd_host_model_inst (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data),
        .layout_nv(m_env[BIT_SECTOR_LAYOUT]), .cmd(cmd));

    // Free-running 20 MHz clock.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Pulse tally and timeout; a hang ends the run.
    always @(negedge clk) begin
        cycles++;
        n_res += resume_pulse;
        n_clr += clear_status_pulse;
        n_soft += soft_reset_pulse;
        if (cycles == 4000) begin
            err_count++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic put(input logic [7:0] c, a, d);
        cmd_host_model_inst.push(c, a, d);
    endtask : put

    // Waits for the host queue to empty.
    task automatic drain();
        repeat (40) if (cmd_host_model_inst.pend.size() != 0) @(negedge clk);
        chk(cmd_host_model_inst.pend.size(), 0);
        repeat (3) @(negedge clk);
    endtask : drain

    // Register write; model one-time bits lock after one flip.
    task automatic wr(input int a, input int d);
        int f;
        put(OP_WRITE_ANY_REG, a[7:0], d[7:0]);
        if (a == ADDR_EPB_V) m_ev = d & EPB_V_WR_MASK;
        if (a == ADDR_WRAP_V) m_wv = d & WRAP_MASK;
        f = (m_env ^ d) & EPB_NV_MASK & ~m_eu;
        if (a == ADDR_EPB_NV) begin
            m_env ^= f;
            m_eu |= f;
        end
        f = (m_wnv ^ d) & WRAP_MASK & ~m_wu;
        if (a == ADDR_WRAP_NV) begin
            m_wnv ^= f;
            m_wu |= f;
        end
    endtask : wr

    task automatic reload();
        m_ev = m_env & EPB_V_WR_MASK;
        m_wv = m_wnv;
    endtask : reload

    function automatic int rd_model(input logic [7:0] a);
        case (a)
            ADDR_EPB_NV: return m_env;
            ADDR_EPB_V:  return m_ev | (m_env & (1 << BIT_SECTOR_LAYOUT));
            ADDR_WRAP_NV: return m_wnv;
            ADDR_WRAP_V: return m_wv;
            default:     return 0;
        endcase
    endfunction : rd_model

    task automatic pop(input int exp);
        chk(cmd_host_model_inst.rsp.size() != 0, 1);
        if (cmd_host_model_inst.rsp.size() != 0) chk(cmd_host_model_inst.rsp.pop_front(), exp);
    endtask : pop

    // Reads all four registers and one unmapped address.
    task automatic check_regs();
        logic [7:0] a [5];
        a = '{ADDR_EPB_NV, ADDR_EPB_V, ADDR_WRAP_NV, ADDR_WRAP_V, 8'h2A};
        foreach (a[i]) put(OP_READ_ANY_REG, a[i], 8'h00);
        drain();
        foreach (a[i]) pop(rd_model(a[i]));
    endtask : check_regs

    // Random loads, addresses and read kinds.
    task automatic check_outs(input int n);
        int            r;
        logic [AW-1:0] a;
        logic [8:0]    la;
        repeat (n) begin
            @(negedge clk);
            r = $random(seed);
            a = $random(seed);
            la = $random(seed);
            if (r[1:0] == 0) a[AW-1:PARAM_REGION_BITS] = '0;
            if (r[1:0] == 1) a[AW-1:PARAM_REGION_BITS] = '1;
            {array_addr, load_addr, load_valid, param_at_top} = {a, la, 1'b1, r[2]};
            {read_is_quad_io, read_is_main_array} = r[4:3];
            @(negedge clk);
            load_valid = 1'b0;
            chk(page_buf_index, m_ev[BIT_PAGE_WRAP] ? la : {1'b0, la[7:0]});
            chk(in_param_sector, !m_env[BIT_SECTOR_LAYOUT] && (r[2] ?
                &a[AW-1:PARAM_REGION_BITS] : ~|a[AW-1:PARAM_REGION_BITS]));
            chk(wrap_active, !m_wv[BIT_WRAP_DISABLE] && r[4] && r[3]);
            chk(wrap_bytes, 8 << m_wv[1:0]);
            chk(output_drive_select, m_wv[7:5] == 0 ? 3 : m_wv[7:5]);
        end
    endtask : check_outs

    // One erase; a scan ends at random by zero, completion or both.
    task automatic erase(input int k, input int ok);
        int         r;
        logic [2:0] e;
        @(negedge clk);
        {erase_req, erase_kind, prev_erase_ok} = {1'b1, k[1:0], ok[0]};
        @(negedge clk);
        erase_req = 1'b0;
        e = (k == 3 || (k == ERASE_PARAM && m_env[BIT_SECTOR_LAYOUT])) ? 3'b001 :
            (m_ev[BIT_BLANK_CHECK] && ok) ? 3'b010 : 3'b100;
        chk({erase_start, scan_start, erase_reject}, e);
        if (e == 3'b010) begin
            r = 1 + {$random(seed)} % 3;
            repeat (2) @(negedge clk);
            {scan_zero_found, scan_done} = {r[0], r[1]};
            @(negedge clk);
            {scan_zero_found, scan_done} = 2'b00;
            chk({erase_start, erase_skip}, r[0] ? 2'b10 : 2'b01);
        end
    endtask : erase

    task automatic erase_all();
        for (int b = 0; b < 2; b++) begin
            wr(ADDR_EPB_V, b << BIT_BLANK_CHECK);
            drain();
            for (int k = 0; k < 4; k++) begin
                erase(k, 0);
                erase(k, 1);
            end
        end
        $display("test erase done");
    endtask : erase_all

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    // Main sequence.
    initial begin
        int d;
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(negedge clk);
        wr(8'h2A, 8'h5A);
        check_regs();
        check_outs(4);
        $display("test reset done");
        wr(ADDR_EPB_V, 8'hFF);
        for (int i = 0; i < 8; i++) begin
            d = (i << 5) | (i & 3) | ((i & 4) << 2);
            if (i[0]) begin
                put(OP_BURST_LEN_SET, 8'h00, d[7:0]);
                m_wv = d & WRAP_MASK;
            end else wr(ADDR_WRAP_V, d);
            drain();
            check_outs(2);
        end
        check_regs();
        $display("test wrap done");
        erase_all();
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_EPB_V, ((s & 2) << 1) | (s & 1));
            put(OP_RESUME_OR_CLR, 8'h00, 8'h00);
            put(OP_LEGACY_RESET, 8'h00, 8'h00);
            e_res += s[1];
            e_clr += !s[1];
            e_soft += s[0];
            if (s[0]) reload();
            drain();
            chk(n_res * 65536 + n_clr * 256 + n_soft, e_res * 65536 + e_clr * 256 + e_soft);
        end
        wr(ADDR_WRAP_V, 8'h13);
        put(OP_RESET_ENABLE, 8'h00, 8'h00);
        put(OP_RESET_DO, 8'h00, 8'h00);
        e_soft++;
        reload();
        check_regs();
        wr(ADDR_WRAP_V, 8'h12);
        put(OP_RESET_ENABLE, 8'h00, 8'h00);
        put(OP_READ_ANY_REG, ADDR_EPB_NV, 8'h00);
        put(OP_RESET_DO, 8'h00, 8'h00);
        drain();
        pop(m_env);
        chk(n_soft, e_soft);
        @(negedge clk) hw_reset_req = 1'b1;
        @(negedge clk) hw_reset_req = 1'b0;
        reload();
        check_regs();
        $display("test command done");
        wr(ADDR_EPB_NV, m_env | 8'h08);
        wr(ADDR_EPB_NV, m_env ^ 8'h08);
        wr(ADDR_WRAP_NV, 8'hFF);
        wr(ADDR_WRAP_NV, 8'h00);
        check_regs();
        check_outs(3);
        $display("test nonvolatile done");
        erase_all();
        conclude();
    end
endmodule : flash_cmd_behaviour_config_tb
